/* verilog/jtbs_cfg.svh */
`ifndef JTBS_CFG_SVH
`define JTBS_CFG_SVH

// ==========================================
// Instruction register
`define JTBS_IR_W 4
`define JTBS_OP_EXTEST 4'h0
`define JTBS_OP_SAMPLE 4'h1
`define JTBS_OP_IDCODE 4'h4
`define JTBS_OP_CLAMP 4'h6
`define JTBS_OP_HIGHZ 4'h7
`define JTBS_OP_BYPASS 4'hF
`define JTBS_IR_CAPTURE 4'hD

// ==========================================
// Data registers
`define JTBS_ID_W 32
`define JTBS_LEN 457

// ==========================================
// Boundary chain layout, cell 0 next to the serial output
`define JTBS_IN_HEAD_LO 451
`define JTBS_SOLO_OE 450
`define JTBS_SOLO_OUT 449
`define JTBS_PORT_LO 17
`define JTBS_DBG_LO 2
`define JTBS_DBG_OE_MASK 16'h9248

`endif

/* verilog/jtbs_pkg.sv */
`default_nettype none
`include "jtbs_cfg.svh"

package jtbs_pkg;

   typedef enum logic [3:0] {
      ST_TLR, ST_RTI,
      ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PAU_DR, ST_EX2_DR, ST_UPD_DR,
      ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PAU_IR, ST_EX2_IR, ST_UPD_IR
   } jtbs_state_t;

   typedef enum logic [2:0] {
      I_EXTEST, I_SAMPLE, I_IDCODE, I_CLAMP, I_HIGHZ, I_BYPASS
   } jtbs_instr_t;

   typedef enum logic [1:0] {C_IN, C_OUT, C_OE} jtbs_cell_t;

   // Core-side view of every boundary cell
   typedef struct packed {
      logic [`JTBS_LEN-1:0] val;
      logic [`JTBS_LEN-1:0] pull;
   } jtbs_core_t;

endpackage

`default_nettype wire

/* verilog/jtbs_tap.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jtbs_cfg.svh"

// Contract
// - Next TAP state follows TMS sampled on each TCK rising edge.
// - TDI sampled on rising edge, selected path shifts on falling edge.
// - TDO driven only in Shift-DR and Shift-IR, otherwise high impedance.
// - TRST forces Test-Logic-Reset at once, without any TCK edge.
// - BYPASS puts one-bit bypass register in path, system untouched.
// - SAMPLE keeps pins normal and captures a core/pin snapshot.
// - SAMPLE/PRELOAD update copies the chain into the output latch.
// - EXTEST drives output pins from the output latch always.
// - EXTEST drives latched data out and captures board response in.
// - Output-cell values captured under EXTEST never drive the board.
// - CLAMP drives latch values, chain holds, bypass forms path.
// - HIGHZ floats outputs, chain holds, bypass forms path.
// - IDCODE becomes active on TRST or in Test-Logic-Reset.
// - Clock, reset, JTAG, mode, debug clock and analog pins stay out.
// - HIGHZ leaves trace-debug pins and pulled port pins alone.
// - Four-bit instruction codes; unknown codes act as BYPASS.
// - Bypass register unreset, cleared in Capture-DR, first bit out 0.
// - Boundary chain is 457 bits, never reset, for SAMPLE and EXTEST.
// - IDCODE selects a read-only 32-bit identification register.
module jtbs_tap #(
   // Identification value is arbitrary; bit 0 is 1 as the standard asks
   parameter logic [`JTBS_ID_W-1:0] ID_CODE = 32'h0000_1001,
   parameter logic [`JTBS_LEN-1:0] HIZ_EXEMPT = `JTBS_LEN'(`JTBS_DBG_OE_MASK)
) (
   // System clock domain
   input wire logic clk_sys,
   input wire logic rstn,
   output logic sys_bscan_hold,
   // Test link
   input wire logic tck,
   input wire logic trst_n,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo_o,
   output logic tdo_oe,
   // Pads
   input wire jtbs_pkg::jtbs_core_t core_i,
   input wire logic [`JTBS_LEN-1:0] pin_in,
   output logic [`JTBS_LEN-1:0] pad_o
);
   import jtbs_pkg::*;

   // ==========================================
   // Functions
   function automatic jtbs_state_t tap_next(input jtbs_state_t s, input logic m);
      case (s)
         ST_TLR: tap_next = m ? ST_TLR : ST_RTI;
         ST_RTI: tap_next = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
         ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
         ST_SH_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
         ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
         ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
         ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
         ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_RTI;
         ST_SEL_IR: tap_next = m ? ST_TLR : ST_CAP_IR;
         ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
         ST_SH_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
         ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
         ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
         ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
         ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_RTI;
         default: tap_next = ST_TLR;
      endcase
   endfunction

   function automatic jtbs_instr_t ir_decode(input logic [`JTBS_IR_W-1:0] c);
      case (c)
         `JTBS_OP_EXTEST: ir_decode = I_EXTEST;
         `JTBS_OP_SAMPLE: ir_decode = I_SAMPLE;
         `JTBS_OP_IDCODE: ir_decode = I_IDCODE;
         `JTBS_OP_CLAMP: ir_decode = I_CLAMP;
         `JTBS_OP_HIGHZ: ir_decode = I_HIGHZ;
         default: ir_decode = I_BYPASS;
      endcase
   endfunction

   // Excluded pins have no cell at all, so the layout is the whole story
   function automatic jtbs_cell_t cell_kind(input int i);
      if (i >= `JTBS_IN_HEAD_LO) begin
         cell_kind = C_IN;
      end else if (i == `JTBS_SOLO_OE) begin
         cell_kind = C_OE;
      end else if (i == `JTBS_SOLO_OUT) begin
         cell_kind = C_OUT;
      end else if (i >= `JTBS_PORT_LO) begin
         case ((i - `JTBS_PORT_LO) % 3)
            0: cell_kind = C_IN;
            1: cell_kind = C_OUT;
            default: cell_kind = C_OE;
         endcase
      end else if (i >= `JTBS_DBG_LO) begin
         // Debug pins order their cells input, enable, output
         case ((i - `JTBS_DBG_LO) % 3)
            0: cell_kind = C_IN;
            1: cell_kind = C_OE;
            default: cell_kind = C_OUT;
         endcase
      end else begin
         cell_kind = C_IN;
      end
   endfunction

   // ==========================================
   // TAP controller (rising edge)
   jtbs_state_t state_q;
   jtbs_state_t act_q;
   logic tdi_q;

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         state_q <= ST_TLR;
      end else begin
         state_q <= tap_next(state_q, tms);
      end
   end

   // Action of the state just left, carried out on the following falling edge
   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         act_q <= ST_TLR;
         tdi_q <= 1'b0;
      end else begin
         act_q <= state_q;
         tdi_q <= tdi;
      end
   end

   // ==========================================
   // Instruction register (falling edge)
   logic [`JTBS_IR_W-1:0] ir_sr_q;
   logic [`JTBS_IR_W-1:0] ir_q;
   logic [`JTBS_IR_W-1:0] ir_d;
   logic test_q;
   jtbs_instr_t instr;

   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_sr_q <= `JTBS_IR_CAPTURE;
      end else if (act_q == ST_CAP_IR) begin
         ir_sr_q <= `JTBS_IR_CAPTURE;
      end else if (act_q == ST_SH_IR) begin
         ir_sr_q <= {tdi_q, ir_sr_q[`JTBS_IR_W-1:1]};
      end
   end

   always_comb begin
      ir_d = ir_q;
      if (state_q == ST_TLR) begin
         ir_d = `JTBS_OP_IDCODE;
      end else if (act_q == ST_UPD_IR) begin
         ir_d = ir_sr_q;
      end
   end

   // Test level kept as a flop so that the system side syncs a clean signal
   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         ir_q <= `JTBS_OP_IDCODE;
         test_q <= 1'b0;
      end else begin
         ir_q <= ir_d;
         test_q <= ir_decode(ir_d) inside {I_EXTEST, I_CLAMP, I_HIGHZ};
      end
   end

   assign instr = ir_decode(ir_q);

   // ==========================================
   // Data registers (falling edge)
   logic sel_bsr;
   logic sel_id;
   logic byp_q;
   logic [`JTBS_ID_W-1:0] id_q;
   logic [`JTBS_LEN-1:0] bsr_q;
   logic [`JTBS_LEN-1:0] upd_q;
   logic [`JTBS_LEN-1:0] cap_v;

   assign sel_bsr = (instr == I_SAMPLE) || (instr == I_EXTEST);
   assign sel_id = (instr == I_IDCODE);

   // No reset: the bypass bit is defined by its capture only
   always_ff @(negedge tck) begin
      if (!sel_bsr && !sel_id && act_q == ST_CAP_DR) begin
         byp_q <= 1'b0;
      end else if (!sel_bsr && !sel_id && act_q == ST_SH_DR) begin
         byp_q <= tdi_q;
      end
   end

   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         id_q <= ID_CODE;
      end else if (sel_id && act_q == ST_CAP_DR) begin
         id_q <= ID_CODE;
      end else if (sel_id && act_q == ST_SH_DR) begin
         id_q <= {tdi_q, id_q[`JTBS_ID_W-1:1]};
      end
   end

   // Output cells capture the latch under EXTEST; that value is only shifted out
   always_comb begin
      for (int i = 0; i < `JTBS_LEN; i++) begin
         if (cell_kind(i) == C_IN) begin
            cap_v[i] = pin_in[i];
         end else if (instr == I_EXTEST) begin
            cap_v[i] = upd_q[i];
         end else begin
            cap_v[i] = core_i.val[i];
         end
      end
   end

   // Chain and latch never reset; CLAMP and HIGHZ leave both untouched
   always_ff @(negedge tck) begin
      if (sel_bsr && act_q == ST_CAP_DR) begin
         bsr_q <= cap_v;
      end else if (sel_bsr && act_q == ST_SH_DR) begin
         bsr_q <= {tdi_q, bsr_q[`JTBS_LEN-1:1]};
      end
   end

   always_ff @(negedge tck) begin
      if (sel_bsr && act_q == ST_UPD_DR) begin
         upd_q <= bsr_q;
      end
   end

   // ==========================================
   // Serial output
   logic oe_q;

   always_ff @(negedge tck or negedge trst_n) begin
      if (!trst_n) begin
         oe_q <= 1'b0;
      end else begin
         oe_q <= (state_q == ST_SH_DR) || (state_q == ST_SH_IR);
      end
   end

   assign tdo_oe = oe_q;

   always_comb begin
      if (state_q == ST_SH_IR || act_q == ST_SH_IR) begin
         tdo_o = ir_sr_q[0];
      end else if (sel_bsr) begin
         tdo_o = bsr_q[0];
      end else if (sel_id) begin
         tdo_o = id_q[0];
      end else begin
         tdo_o = byp_q;
      end
   end

   // ==========================================
   // Pad multiplexer
   always_comb begin
      for (int i = 0; i < `JTBS_LEN; i++) begin
         if (instr == I_EXTEST || instr == I_CLAMP) begin
            pad_o[i] = upd_q[i];
         end else if (instr == I_HIGHZ && cell_kind(i) == C_OE
                      && !HIZ_EXEMPT[i] && !core_i.pull[i]) begin
            pad_o[i] = 1'b0;
         end else begin
            pad_o[i] = core_i.val[i];
         end
      end
   end

   // ==========================================
   // System clock side
   logic hold_s1_q;
   logic hold_s2_q;

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         hold_s1_q <= 1'b0;
         hold_s2_q <= 1'b0;
      end else begin
         hold_s1_q <= test_q;
         hold_s2_q <= hold_s1_q;
      end
   end

   assign sys_bscan_hold = hold_s2_q;

   // ==========================================
   // Checks
   sequence five_ones_s;
      tms [*5];
   endsequence

   tms_reset_a: assert property (
      @(posedge tck) disable iff (!trst_n) five_ones_s |=> state_q == ST_TLR)
      else $error("five TMS ones did not reach reset state");

   tlr_leave_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      (state_q == ST_TLR && !tms) |=> state_q == ST_RTI)
      else $error("reset state did not move to idle");

   trst_entry_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      $rose(trst_n) |-> (state_q == ST_TLR && ir_q == `JTBS_OP_IDCODE))
      else $error("TRST did not force reset state");

   tdo_float_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      !(state_q inside {ST_SH_DR, ST_SH_IR}) |-> !tdo_oe)
      else $error("TDO driven outside shift states");

   tlr_idcode_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      state_q == ST_TLR |=> instr == I_IDCODE)
      else $error("IDCODE not selected in reset state");

   bypass_clear_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      (state_q == ST_CAP_DR && instr == I_BYPASS) |=> !byp_q)
      else $error("bypass bit not cleared on capture");

   bypass_shift_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      (state_q == ST_SH_DR && instr == I_BYPASS) |=> byp_q == $past(tdi))
      else $error("bypass bit did not take TDI");

   chain_hold_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      (instr inside {I_CLAMP, I_HIGHZ}) |=> $stable(bsr_q))
      else $error("chain changed under CLAMP or HIGHZ");

   latch_update_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      (state_q == ST_UPD_DR && sel_bsr) |=> upd_q == $past(bsr_q))
      else $error("output latch not loaded on update");

   extest_pads_a: assert property (
      @(posedge tck) disable iff (!trst_n) instr == I_EXTEST |-> pad_o == upd_q)
      else $error("EXTEST pads not from latch");

   sample_pads_a: assert property (
      @(posedge tck) disable iff (!trst_n) instr == I_SAMPLE |-> pad_o == core_i.val)
      else $error("SAMPLE disturbed the pads");

   highz_pad_a: assert property (
      @(posedge tck) disable iff (!trst_n)
      (instr == I_HIGHZ && !core_i.pull[`JTBS_SOLO_OE]) |-> !pad_o[`JTBS_SOLO_OE])
      else $error("HIGHZ left an output enabled");

endmodule

`default_nettype wire

/* verification/jtbs_host.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Host side of the test link
module jtbs_host (
   // Link
   output logic tck,
   output logic trst_n,
   output logic tms,
   output logic tdi,
   input wire logic tdo_o,
   input wire logic tdo_oe
);
   logic tdo_pin;
   // Released pin floats, so a stale bit can never pass
   assign tdo_pin = tdo_oe ? tdo_o : 1'bz;
   // Start high, then fall, so the test port sees a real reset edge
   initial begin
      tck = 1'b0;
      trst_n = 1'b1;
      tms = 1'b1;
      tdi = 1'b0;
      #1 trst_n = 1'b0;
   end
   task automatic trst(input logic v);
      trst_n = v;
   endtask
   // Clock stands low between frames
   task automatic step(input logic m, input logic d, output logic q);
      tms = m;
      tdi = d;
      #32 tck = 1'b1;
      q = tdo_pin;
      #32 tck = 1'b0;
   endtask
   task automatic walk(input logic [7:0] bits, input int n);
      logic q;
      for (int i = 0; i < n; i++) step(bits[i], 1'b0, q);
   endtask
   // Idle to Shift-DR or Shift-IR, n bits, back to idle
   task automatic scan(input logic ir, input int n, input logic [511:0] d,
                       output logic [511:0] q);
      logic b;
      q = '0;
      if (ir) walk(8'h03, 4);
      else walk(8'h01, 3);
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, d[i], b);
         q[i] = b;
      end
      walk(8'h01, 2);
      #5;
   endtask
endmodule
`default_nettype wire

/* verification/test_jtag_boundary_scan_tap.sv */
`timescale 1ns/1ps
`default_nettype none
`include "jtbs_cfg.svh"
module test_jtag_boundary_scan_tap;
   import jtbs_pkg::*;
   localparam int N = `JTBS_LEN;
   // Arbitrary identification value
   localparam logic [31:0] ID_VAL = 32'h1234_5679;
   localparam logic [N-1:0] PAT_A = N'({15{32'hA5C3_0F96}});
   localparam logic [N-1:0] PAT_B = N'({15{32'h3C69_D21E}});
   localparam logic [511:0] PRE = {16{32'h96E1_7B24}};
   localparam logic [N-1:0] VEC = N'({15{32'h0FF0_55AA}});
   logic clk_sys = 1'b0;
   logic rstn = 1'b0;
   logic tck, trst_n, tms, tdi, tdo_o, tdo_oe, sys_bscan_hold;
   jtbs_core_t core_i = '0;
   logic [N-1:0] pin_in = '0;
   logic [N-1:0] pad_o, e_vec, m_vec;
   logic [511:0] q;
   int fails = 0;
   int total_checks = 0;
   always #4 clk_sys = ~clk_sys;
   jtbs_tap #(.ID_CODE(ID_VAL)) jtbs_tap_inst (.clk_sys(clk_sys), .rstn(rstn),
      .sys_bscan_hold(sys_bscan_hold), .tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_i(core_i), .pin_in(pin_in), .pad_o(pad_o));
   jtbs_host jtbs_host_inst (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe));
   // ==========================================
   // Helpers
   task automatic check(input string what, input logic [511:0] exp, input logic [511:0] got);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   function automatic logic is_in(int i);
      if (i == 449 || i == 450) return 1'b0;
      if (i >= 451 || i <= 1) return 1'b1;
      return (i >= 17) ? ((i - 17) % 3 == 0) : ((i - 2) % 3 == 0);
   endfunction
   function automatic logic is_oe(int i);
      if (i == 450) return 1'b1;
      if (i > 450 || i < 2) return 1'b0;
      return (i >= 17) ? ((i - 17) % 3 == 2) : ((i - 2) % 3 == 1);
   endfunction
   task automatic load_ir(input logic [3:0] op);
      jtbs_host_inst.scan(1'b1, 4, 512'(op), q);
      check("ir capture", 512'(4'hD), 512'(q[3:0]));
   endtask
   task automatic bypass_scan;
      jtbs_host_inst.scan(1'b0, 2, 512'(2'b11), q);
      check("bypass path", 512'(2'b10), 512'(q[1:0]));
   endtask
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ==========================================
   // Scenarios
   task automatic t_idcode;
      jtbs_host_inst.scan(1'b0, 32, 512'(0), q);
      check("id after trst", 512'(ID_VAL), 512'(q[31:0]));
      check("tdo released", 512'(1'b0), 512'(tdo_oe));
      load_ir(4'hF);
      jtbs_host_inst.walk(8'h1F, 6);
      jtbs_host_inst.scan(1'b0, 32, 512'(0), q);
      check("id after tlr", 512'(ID_VAL), 512'(q[31:0]));
      jtbs_host_inst.walk(8'h01, 3);
      #5;
      check("tdo driven", 512'(1'b1), 512'(tdo_oe));
      jtbs_host_inst.trst(1'b0);
      #2;
      check("tdo async", 512'(1'b0), 512'(tdo_oe));
      #100 jtbs_host_inst.trst(1'b1);
      jtbs_host_inst.walk(8'h00, 1);
      jtbs_host_inst.scan(1'b0, 32, 512'(0), q);
      check("id after async", 512'(ID_VAL), 512'(q[31:0]));
      $display("test idcode done");
   endtask
   task automatic t_bypass;
      logic [3:0] ops [4] = '{4'hF, 4'hA, 4'h6, 4'h7};
      @(posedge clk_sys);
      core_i.val <= PAT_A;
      pin_in <= PAT_B;
      foreach (ops[k]) begin
         load_ir(ops[k]);
         bypass_scan();
      end
      load_ir(4'hF);
      check("pads in bypass", 512'(PAT_A), 512'(pad_o));
      $display("test bypass done");
   endtask
   task automatic t_sample;
      for (int i = 0; i < N; i++) e_vec[i] = is_in(i) ? PAT_B[i] : PAT_A[i];
      load_ir(4'h1);
      check("pads in sample", 512'(PAT_A), 512'(pad_o));
      jtbs_host_inst.scan(1'b0, N + 2, PRE, q);
      check("sample snapshot", 512'(e_vec), 512'(q[N-1:0]));
      check("chain length", 512'(PRE[1:0]), 512'(q[N+1:N]));
      $display("test sample done");
   endtask
   task automatic t_extest;
      for (int i = 0; i < N; i++) e_vec[i] = is_in(i) ? PAT_B[i] : PRE[i+2];
      load_ir(4'h0);
      check("preloaded pads", 512'(PRE[N+1:2]), 512'(pad_o));
      repeat (5) @(posedge clk_sys);
      check("hold flag set", 512'(1'b1), 512'(sys_bscan_hold));
      jtbs_host_inst.scan(1'b0, N, 512'(VEC), q);
      check("extest capture", 512'(e_vec), 512'(q[N-1:0]));
      check("extest pads", 512'(VEC), 512'(pad_o));
      $display("test extest done");
   endtask
   task automatic t_clamp_highz;
      @(posedge clk_sys);
      core_i.pull <= N'(1) << 448;
      for (int i = 0; i < N; i++) m_vec[i] = is_oe(i) && !(i < 17 || i == 448);
      load_ir(4'h6);
      check("clamp pads", 512'(VEC), 512'(pad_o));
      bypass_scan();
      load_ir(4'h7);
      check("highz enables", 512'(0), 512'(pad_o & m_vec));
      check("highz exempt", 512'(PAT_A & ~m_vec), 512'(pad_o & ~m_vec));
      bypass_scan();
      load_ir(4'h0);
      check("latch held", 512'(VEC), 512'(pad_o));
      load_ir(4'hF);
      repeat (5) @(posedge clk_sys);
      check("hold flag clear", 512'(1'b0), 512'(sys_bscan_hold));
      $display("test clamp highz done");
   endtask
   // ==========================================
   // Main sequence and watchdog
   initial begin
      repeat (10) @(posedge clk_sys);
      check("hold in reset", 512'(1'b0), 512'(sys_bscan_hold));
      rstn <= 1'b1;
      #100 jtbs_host_inst.trst(1'b1);
      jtbs_host_inst.walk(8'h00, 1);
      t_idcode();
      t_bypass();
      t_sample();
      t_extest();
      t_clamp_highz();
      report_and_stop();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      fails++;
      report_and_stop();
   end
endmodule
`default_nettype wire
